// File: hdl/tws_slave_rx.sv
/*
 * slave receiver of a byte-oriented two-wire serial interface with
 * register port, address match, ack control and clock stretching.
 * Assumes scl/sda/sleep come from outside the clk domain, arb_lost
 * comes from master logic on clk, pads resolve the open-drain wires.
 */
`timescale 1ns/10ps
`include "tws_regs.svh"

module tws_slave_rx (
  input  wire logic       clk,          // system clock
  input  wire logic       rstn,         // async reset, active low
  input  wire logic [1:0] reg_addr,     // register offset
  input  wire logic [7:0] reg_wdata,    // write data
  input  wire logic       reg_wr,       // write strobe
  input  wire logic       reg_rd,       // read strobe
  output      logic [7:0] reg_rdata,    // read data, cycle after strobe
  input  wire logic       scl_in,       // bus clock level
  output      logic       scl_out,      // bus clock drive value
  output      logic       scl_oe_n,     // low while pulling scl
  input  wire logic       sda_in,       // bus data level
  output      logic       sda_out,      // bus data drive value
  output      logic       sda_oe_n,     // low while pulling sda
  input  wire logic       deep_sleep,   // part is in a non-idle sleep
  input  wire logic       arb_lost,     // pulse: master lost arbitration
  output      logic       wake_req,     // wake the part on a match
  output      logic       int_flag,     // interrupt flag level
  output      logic       tx_enter,     // pulse: enter slave transmitter
  output      logic       start_queued  // start wanted and bus free
);

  ////////////////////////////////////////////////////////////////////////
  logic [1:0]             rst_sync_reg;
  logic                   rst_n;
  logic                   scl_m_reg, scl_s_reg, scl_d_reg;
  logic                   sda_m_reg, sda_s_reg, sda_d_reg;
  logic                   slp_m_reg, slp_s_reg;
  tws_pkg::tws_state_e    state_reg, state_next;
  logic [3:0]             cnt_reg, cnt_next;
  logic [7:0]             shift_reg, shift_next;
  logic                   ack_reg, ack_next;
  logic                   hold_reg, hold_next;
  logic                   gc_reg, gc_next;
  logic                   arb_reg, busy_reg, wake_reg, tx_reg;
  logic                   int_reg, ackn_reg, sta_reg, sto_reg;
  logic                   wc_reg, en_reg, ie_reg;
  logic [7:0]             own_reg, stat_reg, data_reg, rdata_reg;
  logic                   set_int, data_load, tx_pulse;
  logic [7:0]             stat_val;

  // reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rst_sync_reg <= 2'h0;
    else       rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // pin synchronisers; the third stage only feeds edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m_reg, scl_s_reg, scl_d_reg} <= 3'h7;
      {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
      {slp_m_reg, slp_s_reg}            <= 2'h0;
    end else begin
      {scl_m_reg, scl_s_reg, scl_d_reg} <= {scl_in, scl_m_reg, scl_s_reg};
      {sda_m_reg, sda_s_reg, sda_d_reg} <= {sda_in, sda_m_reg, sda_s_reg};
      {slp_m_reg, slp_s_reg}            <= {deep_sleep, slp_m_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus event decode
  wire scl_rise  = scl_s_reg & ~scl_d_reg;
  wire scl_fall  = ~scl_s_reg & scl_d_reg;
  wire start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  wire stop_det  = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
  wire addressed = (state_reg != tws_pkg::ts_idle) &&
                   (state_reg != tws_pkg::ts_addr);
  wire byte_fall = scl_fall && (cnt_reg == `TWS_BITS) && en_reg &&
                   !start_det && !stop_det;
  wire addr_done = byte_fall && (state_reg == tws_pkg::ts_addr);
  wire data_done = byte_fall && (state_reg == tws_pkg::ts_data);

  // address match; both enables gate recognition
  wire hit_own = (shift_reg[7:1] == own_reg[7:1]);
  wire hit_gc  = (shift_reg == `TWS_GC_ADDR) & own_reg[`TWS_B_GCE];
  wire hit_w   = ackn_reg & en_reg & ((hit_own & ~shift_reg[0]) | hit_gc);
  wire hit_r   = ackn_reg & en_reg & hit_own & shift_reg[0];

  // status codes; gc_reg stands still in the ack step, so no loop via the sequencer
  wire [7:0] addr_code = gc_reg ?
                         (arb_reg ? `TWS_CODE_ARB_GC : `TWS_CODE_GC) :
                         (arb_reg ? `TWS_CODE_ARB : `TWS_CODE_OWN);
  wire [7:0] ack_code  = gc_reg ? `TWS_CODE_GDAT : `TWS_CODE_DAT;
  wire [7:0] nack_code = gc_reg ? `TWS_CODE_GDAT_N : `TWS_CODE_DAT_N;

  ////////////////////////////////////////////////////////////////////////
  // sequencer; start/stop override every state so a lost frame recovers
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    ack_next   = ack_reg;
    hold_next  = hold_reg;
    gc_next    = gc_reg;
    set_int    = 1'b0;
    stat_val   = stat_reg;
    data_load  = 1'b0;
    tx_pulse   = 1'b0;
    if (!en_reg) begin
      state_next = tws_pkg::ts_idle;
      ack_next   = 1'b0;
      hold_next  = 1'b0;
    end else if (stop_det || start_det) begin
      if (addressed) begin
        set_int  = 1'b1;
        stat_val = `TWS_CODE_STOP;
      end
      state_next = start_det ? tws_pkg::ts_addr : tws_pkg::ts_idle;
      cnt_next   = 4'h0;
      ack_next   = 1'b0;
      hold_next  = 1'b0;
    end else begin
      unique case (state_reg)
        tws_pkg::ts_idle: ;
        tws_pkg::ts_addr, tws_pkg::ts_data: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s_reg};
            cnt_next   = cnt_reg + 4'h1;
          end else if (addr_done) begin
            if (hit_w) begin
              ack_next   = 1'b1;
              gc_next    = ~hit_own | shift_reg[0];
              state_next = tws_pkg::ts_aack;
            end else begin
              tx_pulse   = hit_r;
              state_next = tws_pkg::ts_idle;
            end
          end else if (data_done) begin
            data_load  = 1'b1;
            ack_next   = ackn_reg;
            state_next = ackn_reg ? tws_pkg::ts_dack : tws_pkg::ts_dnack;
          end
        end
        tws_pkg::ts_aack, tws_pkg::ts_dack: begin
          if (scl_fall) begin
            ack_next   = 1'b0;
            hold_next  = 1'b1;
            set_int    = 1'b1;
            stat_val   = (state_reg == tws_pkg::ts_aack) ? addr_code : ack_code;
            state_next = tws_pkg::ts_hold;
          end
        end
        tws_pkg::ts_hold: begin
          if (!int_reg) begin
            hold_next  = 1'b0;
            cnt_next   = 4'h0;
            state_next = tws_pkg::ts_data;
          end
        end
        tws_pkg::ts_dnack: begin
          if (scl_fall) begin
            set_int    = 1'b1;
            stat_val   = nack_code;
            state_next = tws_pkg::ts_idle;
          end
        end
        default: state_next = tws_pkg::ts_idle;
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= tws_pkg::ts_idle;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      {ack_reg, hold_reg, gc_reg, tx_reg} <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      {ack_reg, hold_reg, gc_reg, tx_reg} <= {ack_next, hold_next, gc_next, tx_pulse};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port decode
  wire wr_addr = reg_wr && (reg_addr == `TWS_OFF_ADDR);
  wire wr_ctrl = reg_wr && (reg_addr == `TWS_OFF_CTRL);
  wire wr_data = reg_wr && (reg_addr == `TWS_OFF_DATA);
  wire int_clr = wr_ctrl && reg_wdata[`TWS_B_INT];
  wire [7:0] ctrl_rd = {int_reg, ackn_reg, sta_reg, sto_reg,
                        wc_reg, en_reg, 1'b0, ie_reg};
  // low status bits are the prescaler slot and always read zero
  wire [7:0] stat_rd = {stat_reg[7:3], 3'h0};
  wire [7:0] rd_mux  = (reg_addr == `TWS_OFF_ADDR) ? own_reg :
                       (reg_addr == `TWS_OFF_CTRL) ? ctrl_rd :
                       (reg_addr == `TWS_OFF_STAT) ? stat_rd : data_reg;
  // arbitration loss is remembered until the address step uses it or a stop clears it
  wire arb_use = stop_det || (state_reg == tws_pkg::ts_aack && scl_fall);

  // control and own address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      own_reg <= `TWS_RST_ADDR;
      {ackn_reg, sta_reg, sto_reg, en_reg, ie_reg} <= 5'h0;
    end else begin
      if (wr_addr) own_reg <= reg_wdata;
      if (wr_ctrl) begin
        ackn_reg <= reg_wdata[`TWS_B_ACK];
        sta_reg  <= reg_wdata[`TWS_B_STA];
        sto_reg  <= reg_wdata[`TWS_B_STO];
        en_reg   <= reg_wdata[`TWS_B_EN];
        ie_reg   <= reg_wdata[`TWS_B_IE];
      end
    end
  end

  // flags: a hardware set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {int_reg, wc_reg, arb_reg, busy_reg, wake_reg} <= 5'h0;
      stat_reg <= `TWS_RST_STAT;
    end else begin
      int_reg  <= set_int | (int_reg & ~int_clr);
      wc_reg   <= (wr_data & ~int_reg) | (wc_reg & ~(wr_data & int_reg));
      arb_reg  <= arb_lost | (arb_reg & ~arb_use);
      busy_reg <= start_det | (busy_reg & ~stop_det);
      // wake only while stretching in deep sleep; bus clock held
      wake_reg <= slp_s_reg & hold_next;
      if (set_int) stat_reg <= stat_val;
    end
  end

  // data register; received data bytes and writes while the flag is set reach it, never the
  // address, so after a wake-up it may hold a stale byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg  <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      if (data_load) data_reg <= shift_reg;
      else if (wr_data && int_reg) data_reg <= reg_wdata;
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins: open drain, only ever pull low
  assign scl_out      = 1'b0;
  assign scl_oe_n     = ~hold_reg;
  assign sda_out      = 1'b0;
  assign sda_oe_n     = ~ack_reg;
  assign reg_rdata    = rdata_reg;
  assign wake_req     = wake_reg;
  assign int_flag     = int_reg;
  assign tx_enter     = tx_reg;
  // queued start is handed to master logic once the bus is free
  assign start_queued = sta_reg & en_reg & ~busy_reg &
                        (state_reg == tws_pkg::ts_idle);

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire aack_fall = (state_reg == tws_pkg::ts_aack) && scl_fall && en_reg &&
                   !start_det && !stop_det;

  own_ack_a:
    assert property (addr_done && ackn_reg && hit_own && !shift_reg[0]
                     |=> !sda_oe_n ##1 !sda_oe_n)
    else $error("own write address not acknowledged");
  gc_ignore_a:
    assert property (addr_done && shift_reg == `TWS_GC_ADDR && !own_reg[0]
                     && !hit_own |=> sda_oe_n && state_reg == tws_pkg::ts_idle)
    else $error("general call answered while disabled");
  ack_off_a:
    assert property (addr_done && !ackn_reg |=> sda_oe_n)
    else $error("address acknowledged with ack enable low");
  own_stat_a:
    assert property (aack_fall && !gc_reg && !arb_reg
                     |=> int_reg && stat_reg == `TWS_CODE_OWN && !scl_oe_n)
    else $error("status 0x60 missing");
  arb_stat_a:
    assert property (aack_fall && !gc_reg && arb_reg |=> stat_reg == `TWS_CODE_ARB)
    else $error("status 0x68 missing");
  gc_stat_a:
    assert property (aack_fall && gc_reg && !arb_reg
                     |=> int_reg && stat_reg == `TWS_CODE_GC)
    else $error("status 0x70 missing");
  data_keep_a:
    assert property (data_done && ackn_reg && !gc_reg |=> data_reg == $past(shift_reg)
                     ##[1:1000] (int_reg && stat_reg == `TWS_CODE_DAT))
    else $error("received byte or 0x80 missing");
  data_nack_a:
    assert property (data_done && !ackn_reg
                     |=> sda_oe_n && state_reg == tws_pkg::ts_dnack)
    else $error("byte acknowledged with ack enable low");
  stretch_a:
    assert property (state_reg == tws_pkg::ts_hold && int_reg |-> !scl_oe_n)
    else $error("clock released while flag set");
  int_clear_a:
    assert property (int_clr && !set_int |=> !int_reg)
    else $error("interrupt flag not cleared");
  stop_stat_a:
    assert property (stop_det && en_reg && addressed
                     |=> stat_reg == `TWS_CODE_STOP && state_reg == tws_pkg::ts_idle)
    else $error("status 0xA0 missing");
  presc_zero_a:
    assert property (reg_rd && reg_addr == `TWS_OFF_STAT |=> reg_rdata[2:0] == 3'h0)
    else $error("prescaler bits not zero");

  own_seen_c:  cover property (int_reg && stat_reg == `TWS_CODE_OWN);
  gc_seen_c:   cover property (int_reg && stat_reg == `TWS_CODE_GC);
  data_seen_c: cover property (int_reg && stat_reg == `TWS_CODE_DAT);
  stop_seen_c: cover property (int_reg && stat_reg == `TWS_CODE_STOP);

endmodule // tws_slave_rx

// File: pkg/tws_regs.svh
/*
 * register offsets, field positions, reset values and status codes of
 * the two-wire slave receiver. Assumes byte offsets on a 2-bit port.
 */
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// register offsets
`define TWS_OFF_ADDR 2'h0
`define TWS_OFF_CTRL 2'h1
`define TWS_OFF_STAT 2'h2
`define TWS_OFF_DATA 2'h3

// serial_bus_control fields
`define TWS_B_INT 7
`define TWS_B_ACK 6
`define TWS_B_STA 5
`define TWS_B_STO 4
`define TWS_B_WC  3
`define TWS_B_EN  2
`define TWS_B_IE  0
// own_slave_address: general call enable
`define TWS_B_GCE 0

// reset values
`define TWS_RST_ADDR 8'h00
`define TWS_RST_CTRL 8'h00
`define TWS_RST_STAT 8'hF8

// status codes, prescaler bits zero
`define TWS_CODE_OWN    8'h60
`define TWS_CODE_ARB    8'h68
`define TWS_CODE_GC     8'h70
`define TWS_CODE_ARB_GC 8'h78
`define TWS_CODE_DAT    8'h80
`define TWS_CODE_DAT_N  8'h88
`define TWS_CODE_GDAT   8'h90
`define TWS_CODE_GDAT_N 8'h98
`define TWS_CODE_STOP   8'hA0

// bus constants
`define TWS_GC_ADDR   8'h00
`define TWS_BITS      4'h8

`endif

// File: pkg/tws_pkg.sv
/*
 * types of the two-wire slave receiver.
 * Assumes nothing of its surroundings.
 */
package tws_pkg;
  // bus sequencer, gray along idle-addr-ack-hold-data-ack
  typedef enum logic [2:0] {
    ts_idle  = 3'b000,
    ts_addr  = 3'b001,
    ts_aack  = 3'b011,
    ts_hold  = 3'b010,
    ts_data  = 3'b110,
    ts_dack  = 3'b111,
    ts_dnack = 3'b101
  } tws_state_e;
endpackage

// File: bench/tws_master_model.sv
/*
 * bus master transmitter model driving the two wires of the slave receiver.
 * Assumes the bench resolves the wired-and with pull-ups on both wires.
 */
`timescale 1ns/10ps

module tws_master_model (
  output logic       scl_m, // scl pull, 0 pulls low
  output logic       sda_m, // sda pull, 0 pulls low
  input  wire logic  scl,   // resolved scl wire
  input  wire logic  sda    // resolved sda wire
);
  //////////////////////////////////////////////////////////////////////////
  // stretch waits that ran out; the bench counts them as mismatches
  logic [7:0] timeouts = 8'h00;

  // idle bus: both released, scl stands still between frames
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  // release scl, wait out a stretch (bounded), then a high phase of 32 ns
  task automatic rise;
    int n;
    n = 0;
    scl_m = 1'b1;
    while (scl !== 1'b1 && n < 5000) begin
      #8;
      n++;
    end
    if (n >= 5000) timeouts = timeouts + 8'h01;
    #32;
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic start;
    sda_m = 1'b1;
    #16;
    rise;
    sda_m = 1'b0;
    #32;
    scl_m = 1'b0;
    #16;
  endtask

  // stop: sda rises while scl is high
  task automatic stop;
    sda_m = 1'b0;
    #16;
    rise;
    sda_m = 1'b1;
    #32;
  endtask

  // eight bits msb first, then sda released and the ack bit sampled late
  task automatic byte_tx(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda_m = (i < 0) ? 1'b1 : b[i];
      #16;
      rise;
      if (i < 0) ack = sda;
      scl_m = 1'b0;
      #16;
    end
  endtask
endmodule // tws_master_model

// File: bench/tws_slave_rx_tb.sv
/*
 * self-checking bench of the two-wire slave receiver.
 * Assumes the master model in its own file; wires resolved here.
 */
`timescale 1ns/10ps

module tws_slave_rx_tb;
  logic       clk        = 1'b0;
  logic       rstn       = 1'b0;
  logic [1:0] reg_addr   = 2'h0;
  logic [7:0] reg_wdata  = 8'h00;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  logic       deep_sleep = 1'b0;
  logic       arb_lost   = 1'b0;
  logic       tx_seen    = 1'b0;
  logic [7:0] reg_rdata;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, scl_m, sda_m;
  logic       wake_req, int_flag, tx_enter, start_queued;
  int         error_cnt  = 0;
  int         compares   = 0;
  // open-drain wires with pull-ups
  wire        scl        = scl_m & (scl_oe_n | scl_out);
  wire        sda        = sda_m & (sda_oe_n | sda_out);

  //////////////////////////////////////////////////////////////////////////
  tws_slave_rx i_tws_slave_rx (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .deep_sleep(deep_sleep), .arb_lost(arb_lost),
    .wake_req(wake_req), .int_flag(int_flag), .tx_enter(tx_enter),
    .start_queued(start_queued));
  tws_master_model i_tws_master_model (.scl_m(scl_m), .sda_m(sda_m),
    .scl(scl), .sda(sda));

  // clock, and a latch for the one-cycle transmitter pulse
  always #4 clk = ~clk;
  always @(posedge clk) if (tx_enter === 1'b1) tx_seen <= 1'b1;

  //////////////////////////////////////////////////////////////////////////
  // compare, count, report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // register write and read, one strobe cycle each
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // one byte; nonzero status means a flag is due, zero means none
  task automatic xb(input logic [7:0] b, input logic ea, input logic [7:0] es);
    logic a;
    int   n;
    i_tws_master_model.byte_tx(b, a);
    chk({7'h00, a}, {7'h00, ea});
    n = 0;
    if (es != 8'h00) begin
      while (int_flag !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      chk({7'h00, int_flag}, 8'h01);
      rd(2'h2, es);
    end else begin
      repeat (8) @(posedge clk);
      chk({7'h00, int_flag}, 8'h00);
    end
  endtask
  // stop, check any status it raises, clear the flag
  task automatic ends(input logic [7:0] es);
    i_tws_master_model.stop;
    repeat (8) @(posedge clk);
    if (es != 8'h00) rd(2'h2, es);
    wr(2'h1, 8'hC4);
  endtask
  task automatic end_sim;
    chk(i_tws_master_model.timeouts, 8'h00);
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // own address, data acked, ack enable dropped, next byte nacked
  task automatic t_own;
    wr(2'h0, 8'h55);
    wr(2'h1, 8'h44);
    i_tws_master_model.start;
    xb(8'h54, 1'b0, 8'h60);
    chk({7'h00, scl_oe_n}, 8'h00);
    wr(2'h1, 8'hC4);
    repeat (3) @(posedge clk);
    chk({7'h00, scl_oe_n}, 8'h01);
    xb(8'hA5, 1'b0, 8'h80);
    rd(2'h3, 8'hA5);
    wr(2'h1, 8'h84);
    xb(8'h3C, 1'b1, 8'h88);
    ends(8'h00);
  endtask
  // general call with enable set, data acked then nacked
  task automatic t_gcall;
    i_tws_master_model.start;
    xb(8'h00, 1'b0, 8'h70);
    wr(2'h1, 8'hC4);
    xb(8'h5A, 1'b0, 8'h90);
    wr(2'h1, 8'h84);
    xb(8'hC3, 1'b1, 8'h98);
    ends(8'h00);
  endtask
  // lost arbitration then own address, then general call
  task automatic t_arb;
    @(posedge clk) arb_lost <= 1'b1;
    @(posedge clk) arb_lost <= 1'b0;
    i_tws_master_model.start;
    xb(8'h54, 1'b0, 8'h68);
    wr(2'h1, 8'hC4);
    ends(8'hA0);
    @(posedge clk) arb_lost <= 1'b1;
    @(posedge clk) arb_lost <= 1'b0;
    i_tws_master_model.start;
    xb(8'h00, 1'b0, 8'h78);
    wr(2'h1, 8'hC4);
    ends(8'hA0);
  endtask
  // match in deep sleep wakes the part and holds scl
  task automatic t_sleep;
    @(posedge clk) deep_sleep <= 1'b1;
    i_tws_master_model.start;
    xb(8'h54, 1'b0, 8'h60);
    chk({6'h00, wake_req, scl_oe_n}, 8'h02);
    wr(2'h1, 8'hC4);
    repeat (3) @(posedge clk);
    chk({6'h00, wake_req, scl_oe_n}, 8'h01);
    deep_sleep <= 1'b0;
    ends(8'hA0);
  endtask
  // general call ignored, ack enable off then on, read direction
  task automatic t_refuse;
    wr(2'h0, 8'h54);
    i_tws_master_model.start;
    xb(8'h00, 1'b1, 8'h00);
    wr(2'h1, 8'h04);
    i_tws_master_model.start;
    xb(8'h54, 1'b1, 8'h00);
    wr(2'h1, 8'h44);
    i_tws_master_model.start;
    xb(8'h54, 1'b0, 8'h60);
    wr(2'h1, 8'hC4);
    i_tws_master_model.start;
    rd(2'h2, 8'hA0);
    wr(2'h1, 8'hC4);
    xb(8'h55, 1'b1, 8'h00);
    chk({7'h00, tx_seen}, 8'h01);
    ends(8'h00);
  endtask
  // data write without flag collides; start request on a free bus
  task automatic t_collide;
    wr(2'h3, 8'h11);
    rd(2'h1, 8'h4C);
    wr(2'h1, 8'h64);
    repeat (3) @(posedge clk);
    chk({7'h00, start_queued}, 8'h01);
    wr(2'h1, 8'h44);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // reset, reset values, then the scenarios
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'hF8);
    t_own;
    t_gcall;
    t_arb;
    t_sleep;
    t_refuse;
    t_collide;
    end_sim;
  end
  // watchdog, far beyond the roughly 10 us the scenarios need
  initial begin
    #400000;
    error_cnt++;
    end_sim;
  end
endmodule // tws_slave_rx_tb
